// ---- rtl/sdw_defs.vh ----
// Constants and field layout of the serial converter write port
`ifndef SDW_DEFS_VH
`define SDW_DEFS_VH

// Register byte offsets
`define SDW_ADDR_CTRL 4'h0
`define SDW_ADDR_DATA 4'h4
`define SDW_ADDR_STAT 4'h8

// Control fields
`define SDW_CTRL_RISE_BIT 0
`define SDW_CTRL_RST 1'h0

// Data register fields
`define SDW_DATA_CODE_LSB 0
`define SDW_DATA_MODE_LSB 12

// Status fields
`define SDW_STAT_BUSY_BIT 0
`define SDW_STAT_SETTLED_BIT 1
`define SDW_STAT_ABORT_BIT 2
`define SDW_STAT_CNT_LSB 8

// Frame layout, positions in the assembled 16-bit word
`define SDW_FRAME_LEN 16
`define SDW_LAST_BIT 4'hf
`define SDW_MODE_HI 13
`define SDW_MODE_LO 12
`define SDW_CODE_HI 11
`define SDW_CODE_LO 2

// Operating modes
`define SDW_MODE_NORMAL 2'h0
`define SDW_MODE_GND_1K 2'h1
`define SDW_MODE_GND_100K 2'h2
`define SDW_MODE_OPEN 2'h3

// Reset values
`define SDW_CODE_RST 10'h000
`define SDW_MODE_RST 2'h0

// Wake-up interval and its cycle count at the core clock
`define SDW_CLK_MHZ 20
`define SDW_WAKE_NS 2500
`define SDW_WAKE_CYC ((`SDW_WAKE_NS * `SDW_CLK_MHZ + 999) / 1000)

`endif

// ---- rtl/sdw_sync.v ----
// Two-stage synchroniser for a group of pin inputs
module sdw_sync #(
   parameter WIDTH = 3,
   parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b1}}
) (
   input wire core_clk,
   input wire sys_rst,
   input wire [WIDTH-1:0] async_in,
   output reg [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] meta_r;

   // First stage feeds only the second stage; reset to idle pin levels
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         meta_r <= RST_VAL;
         sync_out <= RST_VAL;
      end else begin
         meta_r <= async_in;
         sync_out <= meta_r;
      end
   end

endmodule

// ---- rtl/sdw_port.v ----
// Write-only three-wire serial port of a 10-bit converter with register access
`include "sdw_defs.vh"

module sdw_port #(
   parameter CODE_W = 10,
   parameter WAKE_CYC = `SDW_WAKE_CYC
) (
   input wire core_clk,
   input wire sys_rst,
   // Serial link pins, all driven by the host
   input wire frame_sync_n,
   input wire shift_clk,
   input wire serial_din,
   // Avalon-MM slave
   input wire [3:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output reg [31:0] avs_readdata,
   output reg avs_waitrequest,
   // Converter controls
   output reg [CODE_W-1:0] code_out,
   output reg [1:0] mode_out,
   output reg out_driven,
   output reg out_gnd_1k,
   output reg out_gnd_100k,
   output reg out_open
);

   localparam ST_IDLE = 3'b001;
   localparam ST_SHIFT = 3'b010;
   localparam ST_DONE = 3'b100;

   wire [2:0] pins_s;
   wire sync_n_s;
   wire sclk_s;
   wire din_s;
   reg sync_n_d_r;
   reg sclk_d_r;
   reg [2:0] state_r;
   reg [15:0] shreg_r;
   reg [3:0] bitcnt_r;
   reg rise_sel_r;
   reg abort_r;
   reg [7:0] frames_r;
   reg [12:0] wake_r;
   wire sync_fall;
   wire [1:0] new_mode;
   wire sclk_edge;
   wire [15:0] word;
   wire exec;
   wire access;
   wire clr_abort;

   // Three host-driven inputs, synchronised before use
   // Reset levels match idle pins: sync high, clock low, so no false edge
   sdw_sync #(
      .WIDTH(3),
      .RST_VAL(3'h5)
   ) u_sync (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .async_in({frame_sync_n, shift_clk, serial_din}),
      .sync_out(pins_s)
   );

   assign sync_n_s = pins_s[2];
   assign sclk_s = pins_s[1];
   assign din_s = pins_s[0];

   // Edge detection on synchronised pins
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sync_n_d_r <= 1'b1;
         sclk_d_r <= 1'b0;
      end else begin
         sync_n_d_r <= sync_n_s;
         sclk_d_r <= sclk_s;
      end
   end

   assign sync_fall = sync_n_d_r & ~sync_n_s;
   // Falling edge by default, rising edge when selected
   assign sclk_edge = rise_sel_r ? (~sclk_d_r & sclk_s) : (sclk_d_r & ~sclk_s);
   // Newest bit lands at the bottom, first bit ends at the top
   assign word = {shreg_r[14:0], din_s};
   assign exec = state_r[1] & sclk_edge & (bitcnt_r == `SDW_LAST_BIT);
   // Mode field of the frame being completed
   assign new_mode = word[`SDW_MODE_HI:`SDW_MODE_LO];

   // One-hot output state {open, gnd_100k, gnd_1k, driven} of a mode code
   function [3:0] mode_state;
      input [1:0] mode;
      begin
         if (mode == `SDW_MODE_GND_1K) begin
            mode_state = 4'h2;
         end else if (mode == `SDW_MODE_GND_100K) begin
            mode_state = 4'h4;
         end else if (mode == `SDW_MODE_OPEN) begin
            mode_state = 4'h8;
         end else begin
            mode_state = 4'h1;
         end
      end
   endfunction

   // Frame state machine
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r <= ST_IDLE;
         shreg_r <= 16'h0000;
         bitcnt_r <= 4'h0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (sync_fall) begin
                  state_r <= ST_SHIFT;
                  shreg_r <= 16'h0000;
                  bitcnt_r <= 4'h0;
               end
            end
            ST_SHIFT: begin
               if (sclk_edge) begin
                  shreg_r <= word;
                  bitcnt_r <= bitcnt_r + 4'h1;
                  if (bitcnt_r == `SDW_LAST_BIT) begin
                     state_r <= sync_n_s ? ST_IDLE : ST_DONE;
                  end
               end else if (sync_n_s) begin
                  state_r <= ST_IDLE;
                  shreg_r <= 16'h0000;
                  bitcnt_r <= 4'h0;
               end
            end
            ST_DONE: begin
               // Clock edges ignored until frame sync goes high
               if (sync_n_s) begin
                  state_r <= ST_IDLE;
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // Code and mode update together, only on a complete frame
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         code_out <= `SDW_CODE_RST;
         mode_out <= `SDW_MODE_RST;
         out_driven <= 1'b1;
         out_gnd_1k <= 1'b0;
         out_gnd_100k <= 1'b0;
         out_open <= 1'b0;
      end else if (exec) begin
         code_out <= word[`SDW_CODE_HI:`SDW_CODE_LO];
         mode_out <= new_mode;
         {out_open, out_gnd_100k, out_gnd_1k, out_driven} <= mode_state(new_mode);
      end
      // Otherwise code and mode hold, also across power-down
   end

   // Wake-up countdown after a return to normal mode
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wake_r <= 13'h0000;
      end else if (exec && mode_out != `SDW_MODE_NORMAL &&
                   new_mode == `SDW_MODE_NORMAL) begin
         wake_r <= WAKE_CYC[12:0];
      end else if (wake_r != 13'h0000) begin
         wake_r <= wake_r - 13'h0001;
      end
   end

   // Bus handshake: one wait-free cycle per request
   assign access = (avs_read | avs_write) & ~avs_waitrequest;
   assign clr_abort = access & avs_write & (avs_address == `SDW_ADDR_STAT) &
                      avs_byteenable[0] & avs_writedata[`SDW_STAT_ABORT_BIT];

   // Frame counter and sticky abort flag, set wins over clear
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         frames_r <= 8'h00;
         abort_r <= 1'b0;
      end else begin
         if (exec) begin
            frames_r <= frames_r + 8'h01;
         end
         if (state_r[1] && !sclk_edge && sync_n_s) begin
            abort_r <= 1'b1;
         end else if (clr_abort) begin
            abort_r <= 1'b0;
         end
      end
   end

   // Register slave
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h00000000;
         rise_sel_r <= `SDW_CTRL_RST;
      end else begin
         avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
         if (avs_read && avs_waitrequest) begin
            if (avs_address == `SDW_ADDR_CTRL) begin
               avs_readdata <= {31'h00000000, rise_sel_r};
            end else if (avs_address == `SDW_ADDR_DATA) begin
               avs_readdata <= {18'h00000, mode_out, 2'h0, code_out};
            end else if (avs_address == `SDW_ADDR_STAT) begin
               avs_readdata <= {16'h0000, frames_r, 5'h00, abort_r,
                                (wake_r == 13'h0000), ~state_r[0]};
            end else begin
               avs_readdata <= 32'h00000000;
            end
         end
         if (access && avs_write && avs_address == `SDW_ADDR_CTRL && avs_byteenable[0]) begin
            rise_sel_r <= avs_writedata[`SDW_CTRL_RISE_BIT];
         end
      end
   end

endmodule

// ---- sim/sdw_host.sv ----
// Host model driving the three serial lines of the converter port
module sdw_host (
   input wire core_clk,
   output logic frame_sync_n,
   output logic shift_clk,
   output logic serial_din
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle state of the three one-way lines
   initial begin
      frame_sync_n = 1'b1;
      shift_clk = 1'b0;
      serial_din = 1'b0;
   end
   // Frame sync lowered from a plain output line
   task start;
      @(posedge core_clk) frame_sync_n <= 1'b0;
      repeat (4) @(posedge core_clk);
   endtask
   // Top bit first, set before the rise and held past the fall
   task bits(input [15:0] w, input int n);
      for (int i = 0; i < n; i++) begin
         serial_din <= w[15];
         w = w << 1;
         repeat (2) @(posedge core_clk);
         shift_clk <= 1'b1;
         repeat (4) @(posedge core_clk);
         shift_clk <= 1'b0;
         repeat (2) @(posedge core_clk);
      end
   endtask
   // Released data line shows no stale value
   task stop;
      frame_sync_n <= 1'b1;
      serial_din <= ~serial_din;
      repeat (8) @(posedge core_clk);
   endtask
endmodule

// ---- sim/sdw_port_sva.sv ----
// Assertions on the converter port outputs and bus answers
module sdw_port_sva #(
   parameter CODE_W = 10
) (
   input wire core_clk,
   input wire sys_rst,
   input wire frame_sync_n,
   input wire [3:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_readdata,
   input wire avs_waitrequest,
   input wire [CODE_W-1:0] code_out,
   input wire [1:0] mode_out,
   input wire out_driven,
   input wire out_gnd_1k,
   input wire out_gnd_100k,
   input wire out_open
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] hi_cnt_r;
   // Cycles frame sync stayed high, saturating
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) hi_cnt_r <= 4'h0;
      else if (!frame_sync_n) hi_cnt_r <= 4'h0;
      else if (hi_cnt_r != 4'hf) hi_cnt_r <= hi_cnt_r + 4'h1;
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
   sequence s_done; !avs_waitrequest ##1 avs_waitrequest; endsequence
   property p_answer; s_req |=> s_done; endproperty
   property p_spur; $fell(avs_waitrequest) |-> $past(avs_read || avs_write); endproperty
   property p_unmap;
      avs_read && !avs_waitrequest && !(avs_address inside {4'h0, 4'h4, 4'h8})
         |-> avs_readdata == 32'h0;
   endproperty
   property p_data;
      avs_read && !avs_waitrequest && avs_address == 4'h4
         |-> avs_readdata == {18'h0, mode_out, 2'h0, code_out};
   endproperty
   property p_idle; hi_cnt_r >= 4'h8 |-> $stable(code_out) && $stable(mode_out); endproperty
   property p_code_first; $changed(code_out) |=> $stable(mode_out) [*8]; endproperty
   property p_mode_first; $changed(mode_out) |=> $stable(code_out) [*8]; endproperty
   property p_onehot; $onehot({out_driven, out_gnd_1k, out_gnd_100k, out_open}); endproperty
   property p_decode;
      $stable(mode_out) |-> {out_open, out_gnd_100k, out_gnd_1k, out_driven} == 4'h1 << mode_out;
   endproperty
   a_answer: assert property (p_answer) else $error("bus answer late or long");
   a_spur: assert property (p_spur) else $error("bus answer without request");
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   a_data: assert property (p_data) else $error("data read mismatch");
   a_idle: assert property (p_idle) else $error("output moved while idle");
   a_code_first: assert property (p_code_first) else $error("code and mode split");
   a_mode_first: assert property (p_mode_first) else $error("mode and code split");
   a_onehot: assert property (p_onehot) else $error("output state not one-hot");
   a_decode: assert property (p_decode) else $error("output state wrong");
endmodule
bind sdw_port sdw_port_sva #(.CODE_W(CODE_W)) u_sva (.*);

// ---- sim/tb.sv ----
// Self-checking bench of the converter write port with a serial host model
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fail_count++; \
   $display("[ERR] %0t got %h want %h", $time, (a), (e)); end end
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
   logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
   logic avs_waitrequest, out_driven, out_gnd_1k, out_gnd_100k, out_open;
   logic frame_sync_n, shift_clk, serial_din;
   logic [9:0] code_out;
   logic [1:0] mode_out;
   logic [15:0] w;
   int fail_count = 0, check_count = 0, ec = 0, em = 0, cnt = 0, ab = 0;
   always #25 core_clk = ~core_clk;
   sdw_port uut (.*);
   sdw_host host (.*);
   // One bus access, held until waitrequest is sampled low
   task bus(input bit wr, input [3:0] a, input [31:0] d);
      @(posedge core_clk);
      avs_read <= !wr;
      avs_write <= wr;
      avs_address <= a;
      avs_writedata <= d;
      @(posedge core_clk);
      while (avs_waitrequest !== 1'b0) @(posedge core_clk);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   // Send a frame, update the model, compare pins and registers
   task frame(input [1:0] m, input [9:0] c, input int n, input bit split);
      w = {2'($urandom), m, c, 2'($urandom)};
      host.start();
      if (split) begin
         host.bits(w, 8);
         repeat (12) @(posedge core_clk);
         host.bits(w << 8, 8);
      end else host.bits(w, n);
      host.stop();
      if (n >= 16) begin ec = c; em = m; cnt++; end else ab = 1;
      `CHK(code_out, ec)
      `CHK(mode_out, em)
      `CHK({out_open, out_gnd_100k, out_gnd_1k, out_driven}, 4'h1 << em)
      bus(0, 4'h4, 0);
      `CHK(rd, em * 4096 + ec)
      bus(0, 4'h8, 0);
      `CHK(rd[15:8], cnt % 256)
      `CHK(rd[2], ab)
      `CHK(rd[0], 1'b0)
   endtask
   task summarize;
      $display("checks %0d errors %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Main sequence
   initial begin
      void'($urandom(3));
      repeat (12) @(posedge core_clk);
      `CHK(code_out, 0)
      `CHK({out_open, out_gnd_100k, out_gnd_1k, out_driven, avs_waitrequest}, 5'h3)
      sys_rst <= 1'b0;
      repeat (4) @(posedge core_clk);
      for (int k = 0; k < 8; k++) frame(k % 4, $urandom, 16, k > 3);
      frame(0, $urandom, 10, 0);
      bus(1, 4'h8, 32'h4);
      ab = 0;
      frame(1, $urandom, 20, 0);
      frame(0, $urandom, 16, 0);
      // Wake-up lasts 2.5 us, 50 core cycles: still waking, then settled
      `CHK(rd[1], 1'b0)
      repeat (50) @(posedge core_clk);
      bus(0, 4'h8, 0);
      `CHK(rd[1], 1'b1)
      bus(1, 4'h0, 32'h1);
      bus(0, 4'h0, 0);
      `CHK(rd, 1)
      frame(2, $urandom, 16, 0);
      bus(1, 4'h0, 32'h0);
      avs_byteenable <= 4'he;
      bus(1, 4'h0, 32'h1);
      avs_byteenable <= 4'hf;
      bus(0, 4'h0, 0);
      `CHK(rd, 0)
      bus(0, 4'hc, 0);
      `CHK(rd, 0)
      bus(1, 4'h4, 32'hffff);
      bus(0, 4'h4, 0);
      `CHK(rd, em * 4096 + ec)
      summarize();
   end
   // Watchdog against a hang
   initial begin
      #1000000;
      fail_count++;
      summarize();
   end
endmodule
